// *** shared/hms_map.svh ***
// Register map, field positions and timing counts of the homing method selector.
// Assumes a 100 MHz clock and a 32-bit Avalon-MM slave with word addressing by byte.
// Overview of operation
// - Host writes a method number; device picks reference and start direction from it.
// - Methods 1 to 14 finish on the encoder index pulse.
// - Methods 17 to 30 use switches only, never the index pulse.
// - Methods 17 to 30 travel like their counterpart 16 lower but skip the index search.
// - Methods 33 and 34 reference to the next index pulse, no switch.
// - Method 35 takes the present position, no movement.
// - Negative method means block detection replaces the limit switch.
// - Block methods -1, -2, -7 to -14 also use the index pulse.
// - Block methods -17, -18, -23 to -30 do not use the index pulse.
// - Block homing works only in closed-loop operation.
// - Block is detected when motor current exceeds the block threshold.
// - After block detection keep driving for the blocking duration.
// - Method 1 uses negative limit then index; method 2 positive limit then index.
// - Methods 3 and 4 use the home switch left edge then index.
// - Methods 5 and 6 use the home switch right edge then index.
// - Methods 7-10 watch positive limit, 11-14 negative limit, home switch then index.
// - Methods 7 to 14 give the same result from any start position.
// - Method 17 negative limit, method 18 positive limit, no index.
// - Methods 19,20 left home edge; 21,22 right home edge; no index.
// - Methods 23-26 watch positive side, 27-30 negative side, no index.
// - Method 35 runs even when operation is not enabled.
// - Homing starts when control bit 4 rises in mode 6, stops if it falls.
// - Status bits 13,12,10 report running, idle, homed, done and errors.
// - Status bit 12 set after full completion, cleared during later runs and errors.
`ifndef HMS_MAP_SVH
`define HMS_MAP_SVH

`define HMS_OFS_CONTROL 4'h0
`define HMS_OFS_MODE 4'h1
`define HMS_OFS_METHOD 4'h2
`define HMS_OFS_BLKCUR 4'h3
`define HMS_OFS_BLKTIME 4'h4
`define HMS_OFS_STATUS 4'h5
`define HMS_OFS_POS 4'h6
`define HMS_OFS_CTRLX 4'h7

`define HMS_CTL_START 4
`define HMS_ST_TARGET 10
`define HMS_ST_ATTAINED 12
`define HMS_ST_ERROR 13

`define HMS_MODE_HOMING 8'h06
`define HMS_MS_NS 1000000
`define HMS_CYC_NS 10
`define HMS_MS_CYCLES (`HMS_MS_NS / `HMS_CYC_NS)
`define HMS_BLKTIME_RST 16'h0064
`define HMS_BLKCUR_RST 16'h03E8
`define HMS_SETTLE_CYCLES 8'h10

`endif

// *** shared/hms_pkg.sv ***
// Types of the homing method selector.
// Assumes hms_map.svh holds all numbers.
package hms_pkg;

  typedef enum logic [1:0] {
    HMS_REF_NONE,
    HMS_REF_LIMIT,
    HMS_REF_HOME_LEFT,
    HMS_REF_HOME_RIGHT
  } hms_ref_t;

  // Decoded homing method
  typedef struct packed {
    logic valid;
    logic useIndex;
    logic useBlock;
    logic startPos;
    logic watchPos;
    logic onlyIndex;
    logic hereOnly;
    hms_ref_t refKind;
  } hms_plan_t;

  // Pins from the axis
  typedef struct packed {
    logic limitNeg;
    logic limitPos;
    logic homeSw;
    logic index;
  } hms_pins_t;

  typedef enum logic [2:0] {
    HMS_S_IDLE,
    HMS_S_SEEK,
    HMS_S_BLOCK,
    HMS_S_BACK,
    HMS_S_INDEX,
    HMS_S_STOP
  } hms_state_t;

endpackage

// *** logic/hms_method_decode.sv ***
// Decodes a signed homing method number into a travel plan.
// Assumes a stable method number; purely combinational.
`timescale 1ns/1ns
`include "hms_map.svh"
module hms_method_decode (
  input wire logic signed [7:0] method,
  output hms_pkg::hms_plan_t plan
);

  logic [7:0] mag;
  logic [7:0] base;

  always_comb begin
    plan = '0;
    plan.refKind = hms_pkg::HMS_REF_NONE;
    mag = method[7] ? 8'(-method) : 8'(method);
    // Profiles 17..30 equal 1..14 without index
    base = (mag >= 8'h11 && mag <= 8'h1E) ? 8'(mag - 8'h10) : mag;
    if (mag >= 8'h01 && mag <= 8'h0E) begin
      plan.valid = 1'b1;
      plan.useIndex = 1'b1;
    end else if (mag >= 8'h11 && mag <= 8'h1E) begin
      plan.valid = 1'b1;
      plan.useIndex = 1'b0;
    end
    if (method[7]) begin
      plan.useBlock = 1'b1;
      // Block only for limit and 7..14 style profiles
      if (base >= 8'h03 && base <= 8'h06) begin
        plan.valid = 1'b0;
      end
    end
    unique case (base)
      8'h01: begin
        plan.refKind = hms_pkg::HMS_REF_LIMIT;
        plan.startPos = 1'b0;
      end
      8'h02: begin
        plan.refKind = hms_pkg::HMS_REF_LIMIT;
        plan.startPos = 1'b1;
      end
      8'h03, 8'h04: begin
        plan.refKind = hms_pkg::HMS_REF_HOME_LEFT;
        plan.startPos = base[0];
      end
      8'h05, 8'h06: begin
        plan.refKind = hms_pkg::HMS_REF_HOME_RIGHT;
        plan.startPos = base[0];
      end
      8'h07, 8'h08, 8'h09, 8'h0A: begin
        plan.watchPos = 1'b1;
        plan.startPos = 1'b1;
        plan.refKind = base[1] ? hms_pkg::HMS_REF_HOME_RIGHT : hms_pkg::HMS_REF_HOME_LEFT;
      end
      8'h0B, 8'h0C, 8'h0D, 8'h0E: begin
        plan.watchPos = 1'b0;
        plan.startPos = 1'b0;
        plan.refKind = base[1] ? hms_pkg::HMS_REF_HOME_LEFT : hms_pkg::HMS_REF_HOME_RIGHT;
      end
      8'h21, 8'h22: begin
        if (!method[7]) begin
          plan.valid = 1'b1;
          plan.useIndex = 1'b1;
          plan.onlyIndex = 1'b1;
          plan.startPos = base[0] ? 1'b0 : 1'b1;
        end
      end
      8'h23: begin
        if (!method[7]) begin
          plan.valid = 1'b1;
          plan.hereOnly = 1'b1;
        end
      end
      default: begin
        plan.refKind = hms_pkg::HMS_REF_NONE;
      end
    endcase
  end

endmodule // hms_method_decode

// *** logic/homing_method_selector.sv ***
// Homing sequencer with an Avalon-MM register slave.
// Assumes switch and index pins are asynchronous; motor current and position
// come from same-clock logic; drive speed command goes to the motion core.
//
// Design decisions made here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`include "hms_map.svh"
module homing_method_selector (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire hms_pkg::hms_pins_t pins,
  input wire logic [15:0] motorCurrent,
  input wire logic signed [31:0] actualPosition,
  input wire logic closedLoop,
  input wire logic operationEnabled,
  input wire logic motorStill,
  output logic driveEnable,
  output logic driveDirPos,
  output logic driveSlow,
  output logic homeLatch,
  output logic signed [31:0] homePosition
);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [15:0] controlWord;
  logic [7:0] opMode;
  logic signed [7:0] method;
  logic [15:0] blockCurrent;
  logic [15:0] blockTime;
  logic [2:0] statusBits;
  logic busPhase;

  // One wait cycle for every access
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busPhase <= 1'b0;
    end else begin
      busPhase <= (avsRead || avsWrite) && !busPhase;
    end
  end

  assign avsWaitRequest = (avsRead || avsWrite) && !busPhase;
  wire busWrite = avsWrite && busPhase;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      controlWord <= 16'h0000;
      opMode <= 8'h00;
      method <= 8'h00;
      blockCurrent <= `HMS_BLKCUR_RST;
      blockTime <= `HMS_BLKTIME_RST;
    end else if (busWrite) begin
      unique case (avsAddress)
        `HMS_OFS_CONTROL: begin
          if (avsByteEnable[0]) controlWord[7:0] <= avsWriteData[7:0];
          if (avsByteEnable[1]) controlWord[15:8] <= avsWriteData[15:8];
        end
        `HMS_OFS_MODE: begin
          if (avsByteEnable[0]) opMode <= avsWriteData[7:0];
        end
        `HMS_OFS_METHOD: begin
          if (avsByteEnable[0]) method <= avsWriteData[7:0];
        end
        `HMS_OFS_BLKCUR: begin
          if (avsByteEnable[0]) blockCurrent[7:0] <= avsWriteData[7:0];
          if (avsByteEnable[1]) blockCurrent[15:8] <= avsWriteData[15:8];
        end
        `HMS_OFS_BLKTIME: begin
          if (avsByteEnable[0]) blockTime[7:0] <= avsWriteData[7:0];
          if (avsByteEnable[1]) blockTime[15:8] <= avsWriteData[15:8];
        end
        default: begin
        end
      endcase
    end
  end

  logic [15:0] statusWord;
  always_comb begin
    statusWord = 16'h0000;
    statusWord[`HMS_ST_ERROR] = statusBits[2];
    statusWord[`HMS_ST_ATTAINED] = statusBits[1];
    statusWord[`HMS_ST_TARGET] = statusBits[0];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      avsReadData <= 32'h00000000;
    end else if (avsRead && !busPhase) begin
      unique case (avsAddress)
        `HMS_OFS_CONTROL: avsReadData <= {16'h0000, controlWord};
        `HMS_OFS_MODE: avsReadData <= {24'h000000, opMode};
        `HMS_OFS_METHOD: avsReadData <= {{24{method[7]}}, method};
        `HMS_OFS_BLKCUR: avsReadData <= {16'h0000, blockCurrent};
        `HMS_OFS_BLKTIME: avsReadData <= {16'h0000, blockTime};
        `HMS_OFS_STATUS: avsReadData <= {16'h0000, statusWord};
        `HMS_OFS_POS: avsReadData <= homePosition;
        default: avsReadData <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] syncA;
  logic [3:0] syncB;
  logic [3:0] syncC;
  logic [3:0] pinLevel;
  logic [3:0] pinPrev;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA <= 4'h0;
      syncB <= 4'h0;
      syncC <= 4'h0;
      pinLevel <= 4'h0;
      pinPrev <= 4'h0;
    end else begin
      syncA <= pins;
      syncB <= syncA;
      syncC <= syncB;
      pinPrev <= pinLevel;
      for (int i = 0; i < 4; i++) begin
        if (syncB[i] == syncC[i]) pinLevel[i] <= syncC[i];
      end
    end
  end

  wire limNeg = pinLevel[3];
  wire limPos = pinLevel[2];
  wire homeSw = pinLevel[1];
  wire indexRise = pinLevel[0] && !pinPrev[0];
  wire homeRise = pinLevel[1] && !pinPrev[1];
  wire homeFall = !pinLevel[1] && pinPrev[1];

  // ----------------------------------------------------------------
  // Method decode
  // ----------------------------------------------------------------
  hms_pkg::hms_plan_t plan;
  hms_pkg::hms_plan_t runPlan;

  hms_method_decode decoder (
    .method(method),
    .plan(plan)
  );

  // ----------------------------------------------------------------
  // Start and abort
  // ----------------------------------------------------------------
  logic startPrev;
  wire startBit = controlWord[`HMS_CTL_START];
  wire inHoming = opMode == `HMS_MODE_HOMING;
  wire startEdge = inHoming && startBit && !startPrev;
  wire canRun = plan.valid && (plan.hereOnly || operationEnabled)
    && (!plan.useBlock || closedLoop);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) startPrev <= 1'b0;
    else startPrev <= startBit;
  end

  // ----------------------------------------------------------------
  // Block timing
  // ----------------------------------------------------------------
  logic [23:0] msCount;
  logic [15:0] blockMs;
  wire msTick = msCount == 24'(`HMS_MS_CYCLES - 1);
  hms_pkg::hms_state_t state;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) msCount <= 24'h000000;
    else if (state != hms_pkg::HMS_S_BLOCK || msTick) msCount <= 24'h000000;
    else msCount <= 24'(msCount + 24'h000001);
  end

  wire blockHit = motorCurrent > blockCurrent;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic dirPos;
  logic leftSeen;
  logic attained;
  logic failed;
  wire stopCmd = !startBit || !inHoming;
  wire limitAhead = dirPos ? limPos : limNeg;
  wire endHit = runPlan.useBlock ? blockHit : limitAhead;
  // Edge seen moving: left edge is entry going positive or exit going negative
  wire leftEdge = dirPos ? homeRise : homeFall;
  wire rightEdge = dirPos ? homeFall : homeRise;
  wire wantEdge = runPlan.refKind == hms_pkg::HMS_REF_HOME_LEFT ? leftEdge : rightEdge;
  // Final approach direction for a home edge
  wire approachPos = runPlan.refKind == hms_pkg::HMS_REF_HOME_RIGHT;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= hms_pkg::HMS_S_IDLE;
      runPlan <= '0;
      dirPos <= 1'b0;
      leftSeen <= 1'b0;
      blockMs <= 16'h0000;
      failed <= 1'b0;
      homeLatch <= 1'b0;
      homePosition <= 32'sh00000000;
    end else begin
      homeLatch <= 1'b0;
      unique case (state)
        hms_pkg::HMS_S_IDLE: begin
          if (startEdge && canRun) begin
            runPlan <= plan;
            dirPos <= plan.startPos;
            failed <= 1'b0;
            leftSeen <= 1'b0;
            if (plan.hereOnly) begin
              homePosition <= actualPosition;
              homeLatch <= 1'b1;
              state <= hms_pkg::HMS_S_STOP;
            end else if (plan.onlyIndex) begin
              state <= hms_pkg::HMS_S_INDEX;
            end else begin
              state <= hms_pkg::HMS_S_SEEK;
            end
          end
        end
        hms_pkg::HMS_S_SEEK: begin
          if (stopCmd) begin
            state <= hms_pkg::HMS_S_IDLE;
          end else if (runPlan.refKind == hms_pkg::HMS_REF_LIMIT) begin
            if (endHit) begin
              state <= runPlan.useBlock ? hms_pkg::HMS_S_BLOCK : hms_pkg::HMS_S_BACK;
              blockMs <= 16'h0000;
            end
          end else if (wantEdge && dirPos == approachPos) begin
            state <= runPlan.useIndex ? hms_pkg::HMS_S_INDEX : hms_pkg::HMS_S_STOP;
            if (!runPlan.useIndex) begin
              homePosition <= actualPosition;
              homeLatch <= 1'b1;
            end
          end else if (endHit) begin
            if (runPlan.useBlock) begin
              state <= hms_pkg::HMS_S_BLOCK;
              blockMs <= 16'h0000;
            end else begin
              dirPos <= !dirPos;
            end
          end else if (homeSw && dirPos != approachPos && homeFall == 1'b0) begin
            leftSeen <= 1'b1;
          end
        end
        hms_pkg::HMS_S_BLOCK: begin
          // Keep pushing against the stop for the blocking time
          if (stopCmd) begin
            state <= hms_pkg::HMS_S_IDLE;
          end else if (!blockHit && blockMs == 16'h0000 && msCount == 24'h000000) begin
            failed <= 1'b1;
            state <= hms_pkg::HMS_S_STOP;
          end else if (msTick) begin
            blockMs <= 16'(blockMs + 16'h0001);
            if (16'(blockMs + 16'h0001) >= blockTime) begin
              dirPos <= !dirPos;
              state <= runPlan.refKind == hms_pkg::HMS_REF_LIMIT
                ? hms_pkg::HMS_S_BACK : hms_pkg::HMS_S_SEEK;
            end
          end
        end
        hms_pkg::HMS_S_BACK: begin
          // Leave the limit or block, then latch or hunt index
          if (stopCmd) begin
            state <= hms_pkg::HMS_S_IDLE;
          end else if (runPlan.useBlock ? !blockHit : !(limNeg || limPos)) begin
            if (runPlan.useIndex) begin
              state <= hms_pkg::HMS_S_INDEX;
            end else begin
              homePosition <= actualPosition;
              homeLatch <= 1'b1;
              state <= hms_pkg::HMS_S_STOP;
            end
          end else begin
            dirPos <= !runPlan.startPos;
          end
        end
        hms_pkg::HMS_S_INDEX: begin
          if (stopCmd) begin
            state <= hms_pkg::HMS_S_IDLE;
          end else if (indexRise) begin
            homePosition <= actualPosition;
            homeLatch <= 1'b1;
            state <= hms_pkg::HMS_S_STOP;
          end else if (limNeg || limPos) begin
            failed <= 1'b1;
            state <= hms_pkg::HMS_S_STOP;
          end
        end
        hms_pkg::HMS_S_STOP: begin
          if (stopCmd) state <= hms_pkg::HMS_S_IDLE;
        end
        default: state <= hms_pkg::HMS_S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Homed flag and status
  // ----------------------------------------------------------------
  wire running = state != hms_pkg::HMS_S_IDLE && state != hms_pkg::HMS_S_STOP;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) attained <= 1'b0;
    else if (homeLatch) attained <= 1'b1;
    else if (running || failed) attained <= 1'b0;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      statusBits <= 3'b001;
    end else if (failed) begin
      statusBits <= motorStill ? 3'b101 : 3'b100;
    end else if (running) begin
      statusBits <= 3'b000;
    end else if (attained) begin
      statusBits <= (state == hms_pkg::HMS_S_STOP && motorStill) ? 3'b011 : 3'b010;
    end else begin
      statusBits <= 3'b001;
    end
  end

  // ----------------------------------------------------------------
  // Drive command
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      driveEnable <= 1'b0;
      driveDirPos <= 1'b0;
      driveSlow <= 1'b0;
    end else begin
      driveEnable <= running;
      driveDirPos <= dirPos;
      driveSlow <= state == hms_pkg::HMS_S_INDEX || state == hms_pkg::HMS_S_BACK;
    end
  end

endmodule // homing_method_selector

// *** bench/hms_checker.sv ***
// Port assertions for the homing method selector.
// Assumes a bind from the testbench; one clock domain.
`timescale 1ns/1ns
module hms_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsReadData,
  input wire logic avsWaitRequest,
  input wire hms_pkg::hms_pins_t pins,
  input wire logic driveEnable,
  input wire logic driveDirPos,
  input wire logic homeLatch,
  input wire logic signed [31:0] homePosition
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence sReq;
    (avsRead || avsWrite) && avsWaitRequest;
  endsequence
  sequence sNegPush;
    (driveEnable && !driveDirPos && pins.limitNeg) [*6];
  endsequence
  sequence sPosPush;
    (driveEnable && driveDirPos && pins.limitPos) [*6];
  endsequence
  AST_ACK: assert property (sReq |=> !avsWaitRequest)
    else $error("request not answered in its second cycle");
  AST_WAIT_FIRST: assert property ($rose(avsRead || avsWrite) |-> avsWaitRequest)
    else $error("waitrequest low in first request cycle");
  AST_LATCH_PULSE: assert property (homeLatch |=> !homeLatch)
    else $error("reference latch longer than one cycle");
  AST_RST_IDLE: assert property ($fell(sys_rst) |-> !driveEnable && !homeLatch)
    else $error("motion active right after reset");
  AST_POS_HOLD: assert property ($changed(homePosition) |-> homeLatch || $past(homeLatch))
    else $error("home position changed without a latch");
  AST_READ_STABLE: assert property (!avsRead |=> $stable(avsReadData))
    else $error("read data changed without a read");
  AST_LIMNEG: assert property (sNegPush |-> ##[0:6] (driveDirPos || !driveEnable))
    else $error("kept driving into negative limit");
  AST_LIMPOS: assert property (sPosPush |-> ##[0:6] (!driveDirPos || !driveEnable))
    else $error("kept driving into positive limit");
endmodule // hms_checker

// *** bench/hms_axis_model.sv ***
// Behavioural axis: position, limit and home switches, index, current.
// Assumes one clock; one step a cycle, a quarter of that when slow.
`timescale 1ns/1ns
module hms_axis_model (
  input wire logic clk,
  input wire logic load,
  input wire logic signed [31:0] loadPos,
  input wire logic driveEnable,
  input wire logic driveDirPos,
  input wire logic driveSlow,
  output hms_pkg::hms_pins_t pins,
  output logic [15:0] motorCurrent,
  output logic signed [31:0] actualPosition,
  output logic motorStill
);
  logic [1:0] div = 2'h0;
  logic atWall;
  assign atWall = driveDirPos ? actualPosition >= 32'sh14A : actualPosition <= -32'sh14A;
  always @(posedge clk) begin
    div <= div + 2'h1;
    if (load)
      actualPosition <= loadPos;
    else if (driveEnable && !atWall && (!driveSlow || div == 2'h0))
      actualPosition <= driveDirPos ? actualPosition + 32'sh1 : actualPosition - 32'sh1;
  end
  always_comb begin
    pins.limitNeg = actualPosition <= -32'sh12C;
    pins.limitPos = actualPosition >= 32'sh12C;
    pins.homeSw = actualPosition >= 32'sh0 && actualPosition <= 32'sh64;
    pins.index = actualPosition[6:0] == 7'h40;
    motorCurrent = (driveEnable && atWall) ? 16'h07D0 : 16'h0100;
    motorStill = !driveEnable || atWall;
  end
endmodule // hms_axis_model

// *** bench/testbench.sv ***
// Self-checking bench for the homing method selector.
// Assumes the axis model on the pin side and Avalon-MM tasks on the host side.
`timescale 1ns/1ns
`include "hms_map.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module testbench;
  logic clk, sys_rst, avsRead, avsWrite, closedLoop, operationEnabled, load, wrLow, idxNear;
  logic driveEnable, driveDirPos, driveSlow, homeLatch, motorStill, avsWaitRequest, moved;
  logic [3:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData, lfsr, eV, mV, expQ[$], mskQ[$];
  logic signed [31:0] actualPosition, homePosition, loadPos;
  logic [15:0] motorCurrent;
  hms_pkg::hms_pins_t pins;
  int n_errors, samples_checked, nLatch, idxAge, k, n;
  logic [7:0] tm[9] = '{8'h21, 8'h11, 8'h12, 8'h01, 8'h02, 8'h03, 8'h0A, 8'h13, 8'h1A};
  logic [1:0] tDir[9] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2};
  logic tIdx[9] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [7:0] rej[9] = '{8'h0F, 8'h10, 8'h1F, 8'h20, 8'hFD, 8'hFA, 8'hED, 8'hEA, 8'hEF};

  homing_method_selector dut (.clk(clk), .sys_rst(sys_rst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
    .avsByteEnable(4'hF), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .pins(pins), .motorCurrent(motorCurrent), .actualPosition(actualPosition),
    .closedLoop(closedLoop), .operationEnabled(operationEnabled), .motorStill(motorStill),
    .driveEnable(driveEnable), .driveDirPos(driveDirPos), .driveSlow(driveSlow),
    .homeLatch(homeLatch), .homePosition(homePosition));
  hms_axis_model axis (.clk(clk), .load(load), .loadPos(loadPos), .driveEnable(driveEnable),
    .driveDirPos(driveDirPos), .driveSlow(driveSlow), .pins(pins),
    .motorCurrent(motorCurrent), .actualPosition(actualPosition), .motorStill(motorStill));

  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // Monitors
  // ----------------------------------------
  always @(negedge clk) begin
    wrLow <= avsWaitRequest === 1'b0;
    idxAge <= pins.index ? 0 : idxAge + 1;
    if (driveEnable === 1'b1)
      moved <= 1'b1;
    if (homeLatch === 1'b1) begin
      nLatch <= nLatch + 1;
      idxNear <= idxAge < 12;
    end
    if (avsRead === 1'b1 && avsWaitRequest === 1'b0) begin
      mV = mskQ.pop_front();
      eV = expQ.pop_front();
      `CHK(avsReadData & mV, eV)
    end
  end

  // ----------------------------------------
  // Bus and sequencing tasks
  // ----------------------------------------
  task print_verdict;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int c;
    c = 0;
    @(posedge clk);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do begin
      @(posedge clk);
      c++;
    end while (!wrLow && c < 50);
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
    if (c >= 50) begin
      n_errors++;
      print_verdict();
    end
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back(e);
    mskQ.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic start(input logic [7:0] m);
    bus(1'b1, `HMS_OFS_CONTROL, 32'h0);
    bus(1'b1, `HMS_OFS_METHOD, {{24{m[7]}}, m});
    @(posedge clk);
    moved <= 1'b0;
    bus(1'b1, `HMS_OFS_CONTROL, 32'h10);
  endtask

  task automatic waitFor(input int cnt);
    for (n = 0; n < 30000 && nLatch <= cnt; n++)
      @(posedge clk);
    if (n >= 30000) begin
      n_errors++;
      print_verdict();
    end
    repeat (4) @(posedge clk);
  endtask

  task automatic place(input logic [31:0] p);
    @(posedge clk);
    load <= 1'b1;
    loadPos <= p;
    @(posedge clk);
    load <= 1'b0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {avsRead, avsWrite, load, moved, idxNear, wrLow} = 6'h0;
    {avsAddress, avsWriteData, loadPos, nLatch, idxAge} = '0;
    closedLoop = 1'b1;
    operationEnabled = 1'b0;
    lfsr = 32'h00015595;
    sys_rst = 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`HMS_OFS_BLKCUR, 32'h000003E8, 32'h0000FFFF);
    rd(`HMS_OFS_BLKTIME, 32'h00000064, 32'h0000FFFF);
    rd(`HMS_OFS_STATUS, 32'h00000400, 32'h00003400);
    bus(1'b1, `HMS_OFS_CTRLX, 32'hFFFFFFFF);
    rd(`HMS_OFS_CTRLX, 32'h0, 32'hFFFFFFFF);
    bus(1'b1, `HMS_OFS_METHOD, 32'h000000F2);
    rd(`HMS_OFS_METHOD, 32'hFFFFFFF2, 32'hFFFFFFFF);
    $display("test registers done");
    lfsr = nextRand(nextRand(lfsr));
    place(lfsr);
    bus(1'b1, `HMS_OFS_MODE, {24'h0, `HMS_MODE_HOMING});
    start(8'h23);
    waitFor(0);
    `CHK(moved, 1'b0)
    rd(`HMS_OFS_POS, lfsr, 32'hFFFFFFFF);
    rd(`HMS_OFS_STATUS, 32'h00001400, 32'h00003400);
    $display("test present position done");
    operationEnabled <= 1'b1;
    closedLoop <= 1'b0;
    for (k = 0; k < 9; k++) begin
      start(rej[k]);
      repeat (40) @(posedge clk);
      `CHK(moved, 1'b0)
      `CHK(nLatch, 1)
    end
    closedLoop <= 1'b1;
    $display("test refusals done");
    for (k = 0; k < 9; k++) begin
      place(32'h96);
      start(tm[k]);
      for (n = 0; n < 40 && driveEnable !== 1'b1; n++)
        @(posedge clk);
      @(negedge clk);
      `CHK(driveEnable, 1'b1)
      if (tDir[k] != 2'h2)
        `CHK(driveDirPos, tDir[k][0])
      waitFor(k + 1);
      `CHK(idxNear, tIdx[k])
      rd(`HMS_OFS_STATUS, 32'h00001400, 32'h00003400);
    end
    $display("test methods done");
    place(32'hFFFFFF06);
    start(8'h21);
    repeat (400) @(posedge clk);
    rd(`HMS_OFS_STATUS, 32'h00002400, 32'h00003400);
    $display("test index error done");
    place(32'h96);
    start(8'h11);
    repeat (30) @(posedge clk);
    bus(1'b1, `HMS_OFS_CONTROL, 32'h0);
    for (n = 0; n < 40 && driveEnable !== 1'b0; n++)
      @(posedge clk);
    `CHK(driveEnable, 1'b0)
    rd(`HMS_OFS_STATUS, 32'h00000400, 32'h00003400);
    $display("test abort done");
    print_verdict();
  end
endmodule // testbench

bind homing_method_selector hms_checker chk (.clk, .sys_rst, .avsRead, .avsWrite,
  .avsReadData, .avsWaitRequest, .pins, .driveEnable, .driveDirPos, .homeLatch,
  .homePosition);
